// [design/acr_regs.sv]
// Function
// - Read-only identity word at index 0x07; writes do nothing.
// - Channel register zero at index 0x10, reset value 0x8001.
// - Bit 15 enables channel zero; read/write, set after reset.
// - Several enabled channels are converted in turn without host help.
// - Bit 14 reserved: host writes zero, reads zero, resets to zero.
// - Bits 13:12 pick one of four setups; read/write, reset zero.
// - A setup is four registers applied together for the conversion.
// - Bits 11:10 reserved: host writes zeros, read zero, reset zero.
// - Bits 9:5 pick the positive input; reset picks input zero.
// - Bits 4:0 pick the negative input; reset picks input one.
// - Channel registers at 0x11 to 0x13 share layout, reset 0x0001.
//
// The implementer's own choice: the AXI4-Lite slave port.
module acr_regs #(
	parameter logic [15:0] ID_CODE = 16'h5a3c // Arbitrary identity value
) (
	input  wire logic             sys_clk,    // Clock, 250 MHz
	input  wire logic             rst,        // Synchronous reset
	input  wire logic             ce,         // Clock enable
	input  acr_pkg::acr_axil_req_t axil_req,  // Bus master signals
	output acr_pkg::acr_axil_rsp_t axil_rsp,  // Bus slave signals
	input  wire logic             conv_done,  // Converter finished
	output logic                  conv_start, // Start pulse
	output logic [1:0]            conv_chan,  // Channel converting
	output acr_pkg::acr_cfg_t     conv_cfg,   // Its held settings
	output logic                  conv_busy   // Conversion under way
);

	// Write channel state
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        next_aw_held;
	logic [7:0]  next_aw_addr;
	logic        next_w_held;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;

	// Read channel state
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	// Handshakes and the write that fires
	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              wr_fire;
	logic [7:0]        wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	acr_pkg::acr_dec_t wr_dec;
	acr_pkg::acr_dec_t rd_dec;
	logic [3:0]        ch_wr;
	acr_pkg::acr_cfg_t cfg [acr_pkg::NUM_CHAN];

	// Ready terms; nothing is taken while the clock enable is low
	assign aw_hs   = ce & axil_req.awvalid & ~aw_held & ~bvalid;
	assign w_hs    = ce & axil_req.wvalid & ~w_held & ~bvalid;
	assign ar_hs   = ce & axil_req.arvalid & ~rvalid;

	// Address and data come from the hold register or straight off the bus
	assign wr_addr = aw_held ? aw_addr : axil_req.awaddr;
	assign wr_data = w_held ? w_data : axil_req.wdata;
	assign wr_strb = w_held ? w_strb : axil_req.wstrb;
	assign wr_fire = ce & ~bvalid & (aw_held | aw_hs) & (w_held | w_hs);
	assign wr_dec  = acr_pkg::acr_decode(wr_addr);
	assign rd_dec  = acr_pkg::acr_decode(axil_req.araddr);

	// Per-channel write enables; the identity word has none
	always_comb begin
		ch_wr = 4'h0;
		if (wr_fire && wr_dec.hit_ch) begin
			ch_wr[wr_dec.ch] = 1'b1;
		end
	end

	// Write channel next values
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (bvalid && axil_req.bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_hs) begin
			next_aw_held = 1'b1;
			next_aw_addr = axil_req.awaddr;
		end
		if (w_hs) begin
			next_w_held = 1'b1;
			next_w_data = axil_req.wdata;
			next_w_strb = axil_req.wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (wr_dec.hit_id || wr_dec.hit_ch) begin
				next_bresp = acr_pkg::RESP_OKAY;
			end else begin
				next_bresp = acr_pkg::RESP_DECERR;
			end
		end
	end

	// Write channel registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= acr_pkg::RESP_OKAY;
		end else if (ce) begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
		end
	end

	// Read channel next values; data sits in the low half
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && axil_req.rready) begin
			next_rvalid = 1'b0;
		end
		if (ar_hs) begin
			next_rvalid = 1'b1;
			next_rresp  = acr_pkg::RESP_OKAY;
			if (rd_dec.hit_id) begin
				next_rdata = {16'h0000, ID_CODE};
			end else if (rd_dec.hit_ch) begin
				next_rdata = {16'h0000,
					acr_pkg::acr_to_word(cfg[rd_dec.ch])};
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = acr_pkg::RESP_DECERR;
			end
		end
	end

	// Read channel registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= acr_pkg::RESP_OKAY;
		end else if (ce) begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

	// Bus answers; valids are masked while the clock enable is low
	always_comb begin
		axil_rsp         = '0;
		axil_rsp.awready = ce & ~aw_held & ~bvalid;
		axil_rsp.wready  = ce & ~w_held & ~bvalid;
		axil_rsp.bvalid  = ce & bvalid;
		axil_rsp.bresp   = bresp;
		axil_rsp.arready = ce & ~rvalid;
		axil_rsp.rvalid  = ce & rvalid;
		axil_rsp.rdata   = rdata;
		axil_rsp.rresp   = rresp;
	end

	// The four channel registers; only channel zero starts enabled
	for (genvar i = 0; i < acr_pkg::NUM_CHAN; i++) begin : g_chan
		acr_chan_reg #(
			.RESET_WORD ((i == 0) ? acr_pkg::CH0_RESET
				: acr_pkg::CHN_RESET)
		) u_chan (
			.sys_clk (sys_clk),
			.rst     (rst),
			.ce      (ce),
			.wr_en   (ch_wr[i]),
			.wr_data (wr_data[15:0]),
			.wr_strb (wr_strb[1:0]),
			.cfg     (cfg[i])
		);
	end

	// Conversion sequencer
	acr_seq u_seq (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.ce         (ce),
		.chan_cfg   (cfg),
		.conv_done  (conv_done),
		.conv_start (conv_start),
		.conv_chan  (conv_chan),
		.conv_cfg   (conv_cfg),
		.conv_busy  (conv_busy)
	);

	// Helper words for the checks below
	logic [15:0] ch_word [acr_pkg::NUM_CHAN];
	logic        any_en;
	always_comb begin
		any_en = 1'b0;
		for (int i = 0; i < acr_pkg::NUM_CHAN; i++) begin
			ch_word[i] = acr_pkg::acr_to_word(cfg[i]);
			any_en     = any_en | cfg[i].en;
		end
	end

	// Identity read returns the fixed code next cycle
	a_id_read_value: assert property (
		@(posedge sys_clk) disable iff (rst)
		ar_hs && rd_dec.hit_id |=> rvalid && rdata[15:0] == ID_CODE
		&& rdata[31:16] == 16'h0000)
		else $error("identity read returned a wrong word");

	// A write to the identity word changes neither channel register zero nor three
	a_id_write_ignored: assert property (
		@(posedge sys_clk) disable iff (rst)
		wr_fire && wr_dec.hit_id |=> ch_word[0] == $past(ch_word[0])
		&& ch_word[3] == $past(ch_word[3]))
		else $error("identity write disturbed a channel register");

	// Reset values of all channel registers
	a_chan_reset_vals: assert property (
		@(posedge sys_clk)
		$past(rst) |-> ch_word[0] == acr_pkg::CH0_RESET
		&& ch_word[1] == acr_pkg::CHN_RESET
		&& ch_word[2] == acr_pkg::CHN_RESET
		&& ch_word[3] == acr_pkg::CHN_RESET)
		else $error("channel register reset value wrong");

	// Reserved bits of a channel read come back as zero
	a_reserved_zero: assert property (
		@(posedge sys_clk) disable iff (rst)
		ar_hs && rd_dec.hit_ch |=>
		rdata[14] == 1'b0 && rdata[11:10] == 2'h0)
		else $error("reserved bit read back nonzero");

	// A full-lane write to channel one lands with its reserved bits cleared
	a_chan_write_lands: assert property (
		@(posedge sys_clk) disable iff (rst)
		ch_wr[1] && wr_strb[1:0] == 2'h3 |=> ce == 1'b0
		|| ch_word[1] == ($past(wr_data[15:0]) & 16'hb3ff))
		else $error("channel write did not land as written");

	// Channel two fields follow a write of both lanes
	a_fields_follow: assert property (
		@(posedge sys_clk) disable iff (rst)
		ch_wr[2] && wr_strb[1:0] == 2'h3 && ce |=> cfg[2].neg
		== $past(wr_data[4:0]) && cfg[2].setup == $past(wr_data[13:12]))
		else $error("channel fields did not follow the write");

	// A started conversion belongs to an enabled channel
	a_start_enabled: assert property (
		@(posedge sys_clk) disable iff (rst)
		conv_start |-> conv_busy && conv_cfg.en)
		else $error("conversion started on a disabled channel");

	// Held settings do not move while a conversion runs
	a_cfg_held_run: assert property (
		@(posedge sys_clk) disable iff (rst)
		conv_busy && !conv_start && $past(conv_busy) |->
		$stable(conv_cfg) && $stable(conv_chan))
		else $error("settings changed during a conversion");

	// After a finished conversion the next one starts two cycles on
	sequence s_conv_end;
		ce && conv_busy && conv_done;
	endsequence
	sequence s_idle_pick;
		ce && !conv_busy && any_en;
	endsequence
	a_seq_steps_on: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_conv_end ##1 s_idle_pick |=> conv_start && conv_busy)
		else $error("sequencer did not step to the next channel");

	// Write answer follows the write by one cycle with its decode verdict
	a_write_answer: assert property (
		@(posedge sys_clk) disable iff (rst)
		wr_fire |=> bvalid && ((bresp == acr_pkg::RESP_OKAY)
		== $past(wr_dec.hit_id || wr_dec.hit_ch)))
		else $error("write was not answered");

endmodule : acr_regs

// [design/acr_pkg.sv]
package acr_pkg;

	// Word index of each register; byte address is four times the index
	localparam logic [5:0]  ID_IDX       = 6'h07;
	localparam logic [5:0]  CH_FIRST_IDX = 6'h10;
	localparam logic [5:0]  CH_LAST_IDX  = 6'h13;
	localparam int          NUM_CHAN     = 4;

	// Reset words of the channel registers
	localparam logic [15:0] CH0_RESET    = 16'h8001;
	localparam logic [15:0] CHN_RESET    = 16'h0001;

	// Field positions of a channel register
	localparam int          EN_BIT       = 15;
	localparam int          SETUP_LSB    = 12;
	localparam int          POS_LSB      = 5;
	localparam int          NEG_LSB      = 0;

	// Bus answers and sequencer reset state
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;
	localparam logic [1:0]  LAST_RESET   = 2'h3;

	// Channel settings as the sequencer sees them
	typedef struct packed {
		logic       en;
		logic [1:0] setup;
		logic [4:0] pos;
		logic [4:0] neg;
	} acr_cfg_t;

	// Master to slave signals of the register bus
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} acr_axil_req_t;

	// Slave to master signals of the register bus
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} acr_axil_rsp_t;

	// Result of an address decode
	typedef struct packed {
		logic       hit_id;
		logic       hit_ch;
		logic [1:0] ch;
	} acr_dec_t;

	// Register word to channel settings; reserved bits fall away
	function automatic acr_cfg_t acr_to_cfg(input logic [15:0] w);
		acr_cfg_t c;
		c.en    = w[EN_BIT];
		c.setup = w[SETUP_LSB +: 2];
		c.pos   = w[POS_LSB +: 5];
		c.neg   = w[NEG_LSB +: 5];
		return c;
	endfunction : acr_to_cfg

	// Channel settings to register word; reserved bits read zero
	function automatic logic [15:0] acr_to_word(input acr_cfg_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[EN_BIT]          = c.en;
		w[SETUP_LSB +: 2]  = c.setup;
		w[POS_LSB +: 5]    = c.pos;
		w[NEG_LSB +: 5]    = c.neg;
		return w;
	endfunction : acr_to_word

	// Byte address to register select
	function automatic acr_dec_t acr_decode(input logic [7:0] addr);
		acr_dec_t   d;
		logic [5:0] idx;
		d   = '0;
		idx = addr[7:2];
		if (addr[1:0] != 2'h0) begin
			d = '0;
		end else if (idx == ID_IDX) begin
			d.hit_id = 1'b1;
		end else if (idx >= CH_FIRST_IDX && idx <= CH_LAST_IDX) begin
			d.hit_ch = 1'b1;
			d.ch     = 2'(idx - CH_FIRST_IDX);
		end
		return d;
	endfunction : acr_decode

	// First enabled channel after the last one, wrapping round
	function automatic logic [1:0] acr_next_chan(input logic [3:0] en,
		input logic [1:0] last);
		logic [1:0] c;
		logic [1:0] r;
		logic       found;
		r     = last;
		found = 1'b0;
		for (int k = 1; k <= NUM_CHAN; k++) begin
			c = 2'(last + 2'(k));
			if (en[c] && !found) begin
				r     = c;
				found = 1'b1;
			end
		end
		return r;
	endfunction : acr_next_chan

endpackage : acr_pkg

// [design/acr_chan_reg.sv]
// One channel register with byte-lane writes
module acr_chan_reg #(
	parameter logic [15:0] RESET_WORD = 16'h0001
) (
	input  wire logic            sys_clk, // Clock
	input  wire logic            rst,     // Synchronous reset
	input  wire logic            ce,      // Clock enable
	input  wire logic            wr_en,   // Write this register
	input  wire logic [15:0]     wr_data, // Write data
	input  wire logic [1:0]      wr_strb, // Byte lanes
	output acr_pkg::acr_cfg_t    cfg      // Stored settings
);

	acr_pkg::acr_cfg_t next_cfg;
	logic [15:0]       word;

	// Merge written lanes; reserved bits are dropped on the way back
	always_comb begin
		word = acr_pkg::acr_to_word(cfg);
		if (wr_en) begin
			if (wr_strb[0]) begin
				word[7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				word[15:8] = wr_data[15:8];
			end
		end
		next_cfg = acr_pkg::acr_to_cfg(word);
	end

	// Register the settings
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg <= acr_pkg::acr_to_cfg(RESET_WORD);
		end else if (ce) begin
			cfg <= next_cfg;
		end
	end

endmodule : acr_chan_reg

// [design/acr_seq.sv]
// Steps conversions through the enabled channels
module acr_seq (
	input  wire logic            sys_clk,    // Clock
	input  wire logic            rst,        // Synchronous reset
	input  wire logic            ce,         // Clock enable
	input  acr_pkg::acr_cfg_t    chan_cfg [acr_pkg::NUM_CHAN], // Settings
	input  wire logic            conv_done,  // Conversion finished
	output logic                 conv_start, // Conversion start pulse
	output logic [1:0]           conv_chan,  // Channel converting
	output acr_pkg::acr_cfg_t    conv_cfg,   // Settings held for it
	output logic                 conv_busy   // Conversion under way
);

	typedef enum logic {SEQ_IDLE, SEQ_RUN} acr_seq_state_t;

	acr_seq_state_t    state;
	acr_seq_state_t    next_state;
	logic [1:0]        last;
	logic [1:0]        next_last;
	logic              next_start;
	logic [1:0]        next_chan;
	acr_pkg::acr_cfg_t next_cfg;
	logic [3:0]        en;

	// Pick the next enabled channel and hold its settings for the run
	always_comb begin
		en         = 4'h0;
		next_state = state;
		next_last  = last;
		next_start = 1'b0;
		next_chan  = conv_chan;
		next_cfg   = conv_cfg;
		for (int i = 0; i < acr_pkg::NUM_CHAN; i++) begin
			en[i] = chan_cfg[i].en;
		end
		case (state)
			SEQ_IDLE: begin
				if (|en) begin
					next_chan  = acr_pkg::acr_next_chan(en, last);
					next_cfg   = chan_cfg[next_chan];
					next_last  = next_chan;
					next_start = 1'b1;
					next_state = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (conv_done) begin
					next_state = SEQ_IDLE;
				end
			end
			default: next_state = SEQ_IDLE;
		endcase
	end

	// Register the sequencer state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state      <= SEQ_IDLE;
			last       <= acr_pkg::LAST_RESET;
			conv_start <= 1'b0;
			conv_chan  <= 2'h0;
			conv_cfg   <= '0;
		end else if (ce) begin
			state      <= next_state;
			last       <= next_last;
			conv_start <= next_start;
			conv_chan  <= next_chan;
			conv_cfg   <= next_cfg;
		end
	end

	assign conv_busy = (state == SEQ_RUN);

endmodule : acr_seq

// [verification/acr_conv_model.sv]
// Converter stand-in: answers each start with a done pulse after a delay
module acr_conv_model (
	input  wire logic       sys_clk,    // Clock
	input  wire logic       rst,        // Synchronous reset
	input  wire logic       conv_start, // Start pulse from the block
	input  wire logic [7:0] delay,      // Cycles before done, 0 is prompt
	output logic            conv_done   // One-cycle finish pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt;
	logic       run;

	// Count down the conversion time, then pulse done once
	always @(posedge sys_clk) begin
		if (rst) begin
			run       <= 1'b0;
			cnt       <= 8'h00;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) begin
				run <= 1'b1;
				cnt <= delay;
			end else if (run) begin
				if (cnt == 8'h00) begin
					conv_done <= 1'b1;
					run       <= 1'b0;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
endmodule : acr_conv_model

// [verification/acr_regs_tb.sv]
// Register and sequencing checks for the channel register bank
module acr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   sys_clk;
	logic                   rst;
	logic                   conv_done;
	logic                   conv_start;
	logic                   conv_busy;
	logic [1:0]             conv_chan;
	logic [7:0]             delay;
	acr_pkg::acr_cfg_t      conv_cfg;
	acr_pkg::acr_axil_req_t req;
	acr_pkg::acr_axil_rsp_t rsp;
	int                     miscompares;
	int                     n_compared;
	int                     nstart;
	logic [31:0]            rd;
	logic [1:0]             rs;
	logic [15:0]            wd;
	logic [1:0]             c1, c2, c3;
	logic [12:0]            g1, g2, g3;

	// Clock of 4 ns
	always #2 sys_clk = ~sys_clk;

	// Identity value is arbitrary
	acr_regs #(.ID_CODE(16'h3c5a)) u_dut (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.ce         (1'b1),
		.axil_req   (req),
		.axil_rsp   (rsp),
		.conv_done  (conv_done),
		.conv_start (conv_start),
		.conv_chan  (conv_chan),
		.conv_cfg   (conv_cfg),
		.conv_busy  (conv_busy)
	);

	acr_conv_model u_conv (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.conv_start (conv_start),
		.delay      (delay),
		.conv_done  (conv_done)
	);

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Counts and verdict
	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// A wait ran out
	task automatic give_up;
		miscompares++;
		$display("wrong value at %0t: wait timed out", $time);
		tally_and_finish();
	endtask : give_up

	// Bus write; items are released at the edge that takes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pa, pw, pb, ta, tw, tb;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		r  = 2'h0;
		@(posedge sys_clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.bready  <= 1'b1;
		for (int n = 0; pb; n++) begin
			if (n == 100) give_up();
			@(negedge sys_clk);
			ta = pa && rsp.awready === 1'b1;
			tw = pw && rsp.wready === 1'b1;
			tb = rsp.bvalid === 1'b1;
			r  = rsp.bresp;
			@(posedge sys_clk);
			if (ta) begin
				req.awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				req.wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (tb) begin
				req.bready <= 1'b0;
				pb = 1'b0;
			end
		end
	endtask : wr

	// Bus read, then compare data and response
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic pa, pr, ta;
		pa = 1'b1;
		pr = 1'b1;
		@(posedge sys_clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		for (int n = 0; pr; n++) begin
			if (n == 100) give_up();
			@(negedge sys_clk);
			ta = pa && rsp.arready === 1'b1;
			pr = rsp.rvalid !== 1'b1;
			rd = rsp.rdata;
			rs = rsp.rresp;
			@(posedge sys_clk);
			if (ta) begin
				req.arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (!pr) req.rready <= 1'b0;
		end
		chk(rd, e);
		chk(32'(rs), 32'(er));
	endtask : rc

	// Next start pulse with its channel and held settings
	task automatic wait_start(output logic [1:0] ch, output logic [12:0] g);
		for (int n = 0; n < 400; n++) begin
			@(negedge sys_clk);
			if (conv_start === 1'b1) begin
				ch = conv_chan;
				g  = conv_cfg;
				@(posedge sys_clk);
				return;
			end
		end
		give_up();
	endtask : wait_start

	// Main sequence
	initial begin
		sys_clk     = 1'b0;
		rst         = 1'b1;
		req         = '0;
		delay       = 8'h00;
		miscompares = 0;
		n_compared  = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rc(8'h1c, 32'h0000_3c5a, acr_pkg::RESP_OKAY);
		rc(8'h40, 32'h0000_8001, acr_pkg::RESP_OKAY);
		for (int i = 1; i < 4; i++) begin
			rc(8'(8'h40 + 4 * i), 32'h0000_0001, acr_pkg::RESP_OKAY);
		end
		$display("reset values test done");
		wr(8'h1c, 32'h0000_ffff, rs);
		chk(32'(rs), 32'(acr_pkg::RESP_OKAY));
		rc(8'h1c, 32'h0000_3c5a, acr_pkg::RESP_OKAY);
		wr(8'h40, 32'hffff_ffff, rs);
		rc(8'h40, 32'h0000_b3ff, acr_pkg::RESP_OKAY);
		// Every setup code with the first three positive inputs
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 3; p++) begin
				wd = {1'b1, 1'b0, 2'(s), 2'b00, 5'(p), 5'h01};
				wr(8'h44, {16'hffff, wd | 16'h4c00}, rs);
				rc(8'h44, {16'h0000, wd}, acr_pkg::RESP_OKAY);
			end
		end
		wr(8'h44, 32'h0000_0001, rs);
		wr(8'h20, 32'h0000_1234, rs);
		chk(32'(rs), 32'(acr_pkg::RESP_DECERR));
		rc(8'h20, 32'h0000_0000, acr_pkg::RESP_DECERR);
		rc(8'h42, 32'h0000_0000, acr_pkg::RESP_DECERR);
		$display("register access test done");
		// Channels 0 and 2 enabled: starts alternate between them
		delay <= 8'h03;
		wr(8'h40, 32'h0000_8001, rs);
		wr(8'h48, 32'h0000_a040, rs);
		wait_start(c1, g1);
		wait_start(c1, g1);
		wait_start(c2, g2);
		wait_start(c3, g3);
		chk(32'(c2), (c1 == 2'd0) ? 32'd2 : 32'd0);
		chk(32'(c3), 32'(c1));
		chk(32'(g2), (c2 == 2'd2) ? 32'h1840 : 32'h1001);
		// Slow conversion: a write mid-run leaves held settings alone
		delay <= 8'd40;
		c1 = 2'd0;
		for (int k = 0; k < 4 && c1 != 2'd2; k++) wait_start(c1, g1);
		wr(8'h48, 32'h0000_b040, rs);
		@(negedge sys_clk);
		chk(32'(conv_cfg), 32'h1840);
		chk(32'(conv_busy), 32'd1);
		c1 = 2'd0;
		for (int k = 0; k < 4 && c1 != 2'd2; k++) wait_start(c1, g1);
		chk(32'(g1), 32'h1c40);
		// Shared setup: every active channel is given the same code
		wr(8'h40, 32'h0000_9001, rs);
		wr(8'h48, 32'h0000_9040, rs);
		wait_start(c1, g1);
		wait_start(c2, g2);
		wait_start(c3, g3);
		chk(32'(g2[11:10]), 32'd1);
		chk(32'(g3[11:10]), 32'd1);
		chk(32'(c2 ^ c3), 32'd2);
		$display("sequencing test done");
		// No channel enabled: the sequencer goes quiet
		wr(8'h40, 32'h0000_0001, rs);
		wr(8'h48, 32'h0000_0001, rs);
		repeat (100) @(negedge sys_clk);
		nstart = 0;
		repeat (200) begin
			@(negedge sys_clk);
			if (conv_start !== 1'b0) nstart++;
		end
		chk(32'(nstart), 32'd0);
		$display("idle test done");
		tally_and_finish();
	end
endmodule : acr_regs_tb
